// ### hdl/crm_core.sv
/*
  Programmer-visible core: working registers, stack pointer, program
  counter with prefetch, status word, shadows, loops, exception pick,
  visibility window and table addressing.
  Assumes program and X/Y data memories answer in the same cycle.
*/
`timescale 1ns/1ps
`include "crm_regs.svh"
module crm_core
  import crm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic [3:0] wr_idx,
  input wire logic [15:0] wr_data,
  input wire logic wr_byte,
  input wire logic mem_wr_en,
  input wire logic [3:0] mem_wr_idx,
  input wire logic [1:0] mem_wr_be,
  input wire logic [15:0] mem_wr_data,
  input wire logic [3:0] rd_idx,
  output logic [15:0] rd_data_q,
  output logic [15:0] default_file_reg,
  input wire logic [15:0] x_addr,
  input wire logic [15:0] y_addr,
  input wire logic dual_src,
  output logic y_en,
  input wire logic [23:0] prog_data,
  input wire logic special_mode,
  output logic [22:0] fetch_addr,
  output logic [23:0] exec_instr_q,
  input wire logic pc_load,
  input wire logic [22:0] pc_load_val,
  output logic [22:0] program_counter,
  input wire logic flags_upd,
  input wire crm_flags_t flags_in,
  input wire logic [5:0] dsp_status,
  output logic [15:0] core_flags_word,
  input wire logic shadow_push,
  input wire logic shadow_pop,
  input wire logic loop_begin,
  input wire crm_loop_t loop_in,
  input wire logic rpt_begin,
  input wire logic [13:0] rpt_count,
  input wire logic [7:0] visibility_page_reg,
  input wire logic [7:0] table_page_reg,
  input wire logic [3:0] tbl_idx,
  output logic [22:0] tbl_addr,
  output logic psv_hit,
  output logic psv_stall,
  output logic [22:0] psv_addr,
  output logic [15:0] psv_data_q,
  input wire logic [`CRM_N_TRAP-1:0] trap_pend,
  input wire logic [`CRM_N_IRQ-1:0] irq_pend,
  input wire logic [`CRM_N_IRQ-1:0][2:0] irq_pri,
  output logic exc_ack,
  output logic [5:0] exc_vec_q,
  input wire logic call_req,
  input wire logic ret_req,
  output logic stack_wr_q,
  output logic [15:0] stack_addr_q,
  output logic [15:0] stack_data_q,
  input wire logic [3:0] shift_idx,
  input wire logic shift_use_acc,
  input wire logic [39:0] acc_in,
  input wire logic signed [5:0] shift_amt,
  output logic [39:0] shift_res_q,
  output logic repeat_active_flag,
  output logic loop_active_flag,
  output logic [13:0] repeat_count_reg
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [15:0] w_q [16];
  logic [15:0] w_d [16];
  logic [22:0] pc_q, pc_d;
  logic [23:0] ins_d;
  crm_flags_t fl_q, fl_d, shf_q, shf_d;
  logic [15:0] shw_q [4];
  logic [15:0] shw_d [4];
  logic [2:0] lvl_q, lvl_d;
  logic [5:0] dsp_q, dsp_d;
  logic rpt_on_q, rpt_on_d, lp_on_q, lp_on_d, lsv_q, lsv_d;
  logic [13:0] rc_q, rc_d;
  crm_loop_t lp_q, lp_d, lsh_q, lsh_d;
  logic psvb_q, psvb_d;
  logic [15:0] psvd_d, rd_d, sdat_d, saddr_d;
  logic swr_d;
  logic [5:0] vec_d;
  logic [39:0] sh_in, sh_res;
  logic [3:0] src_pri [`CRM_N_SRC];
  logic [`CRM_N_SRC-1:0] src_pend;
  logic [3:0] best_pri;
  logic [5:0] best_vec;
  logic advance;
  logic [15:0] sp_auto;
  logic sp_touch;

  // ----------------------------------------------------------------------
  // exception sources and pick
  // ----------------------------------------------------------------------
  // traps first in natural order, each with a fixed level above any irq
  for (genvar s = 0; s < `CRM_N_SRC; s++)
  begin : g_src
    if (s < `CRM_N_TRAP)
    begin : g_trap
      assign src_pend[s] = trap_pend[s] & 1'(`CRM_TRAP_LIVE >> s);
      assign src_pri[s] = `CRM_TRAP_PRI + 4'(s);
    end
    else
    begin : g_irq
      assign src_pend[s] = irq_pend[s-`CRM_N_TRAP] & (|irq_pri[s-`CRM_N_TRAP]);
      assign src_pri[s] = {1'b0, irq_pri[s-`CRM_N_TRAP]};
    end
  end

  // strict compare keeps the lowest index on a tie
  always_comb
  begin
    best_pri = 4'h0;
    best_vec = 6'h00;
    for (int i = 0; i < `CRM_N_SRC; i++)
    begin
      if (src_pend[i] && src_pri[i] > best_pri)
      begin
        best_pri = src_pri[i];
        best_vec = 6'(i);
      end
    end
  end

  // ----------------------------------------------------------------------
  // address paths
  // ----------------------------------------------------------------------
  // the top pc bit is masked except in special mode
  assign fetch_addr = {pc_q[22] & special_mode, pc_q[21:0]};
  assign program_counter = pc_q;
  assign y_en = dual_src;
  assign psv_hit = x_addr[`CRM_PSV_BIT];
  assign psv_addr = {visibility_page_reg, x_addr[14:0]};
  assign psv_stall = psv_hit & ~psvb_q;
  assign tbl_addr = {table_page_reg, w_q[tbl_idx][14:0]};
  assign default_file_reg = w_q[`CRM_DEF_IDX];
  assign advance = clk_en & ~psv_stall;
  assign exc_ack = advance & (best_pri > {1'b0, lvl_q});
  assign repeat_active_flag = rpt_on_q;
  assign loop_active_flag = lp_on_q;
  assign repeat_count_reg = rc_q;
  // status word layout
  assign core_flags_word = {dsp_q, lp_on_q, fl_q.dc, lvl_q, rpt_on_q,
                            fl_q.n, fl_q.ov, fl_q.z, fl_q.c};

  // ----------------------------------------------------------------------
  // shifter
  // ----------------------------------------------------------------------
  assign sh_in = shift_use_acc ? acc_in : {{24{w_q[shift_idx][15]}}, w_q[shift_idx]};
  crm_shifter u_shift (
    .val(sh_in),
    .amt(shift_amt),
    .res(sh_res)
  );

  // ----------------------------------------------------------------------
  // stack pointer automatic moves
  // ----------------------------------------------------------------------
  // exception beats call beats return; an explicit write loses to them
  always_comb
  begin
    sp_touch = 1'b1;
    sp_auto = w_q[`CRM_SP_IDX];
    if (exc_ack || call_req)
      sp_auto = w_q[`CRM_SP_IDX] + `CRM_STK_STEP;
    else if (ret_req)
      sp_auto = w_q[`CRM_SP_IDX] - `CRM_STK_STEP;
    else
      sp_touch = 1'b0;
  end

  // ----------------------------------------------------------------------
  // working registers, one entry each
  // ----------------------------------------------------------------------
  for (genvar r = 0; r < 16; r++)
  begin : g_w
    always_comb
    begin
      w_d[r] = w_q[r];
      if (r < 4 && shadow_pop)
        w_d[r] = shw_q[r % 4];
      if (wr_en && wr_idx == 4'(r))
        w_d[r] = wr_byte ? {w_q[r][15:8], wr_data[7:0]} : wr_data;
      // memory-mapped path can reach the high byte as well
      if (mem_wr_en && mem_wr_idx == 4'(r))
      begin
        if (mem_wr_be[0])
          w_d[r][7:0] = mem_wr_data[7:0];
        if (mem_wr_be[1])
          w_d[r][15:8] = mem_wr_data[15:8];
      end
      if (4'(r) == `CRM_SP_IDX && sp_touch)
        w_d[r] = sp_auto;
      if (4'(r) == `CRM_SP_IDX)
        w_d[r][0] = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // sequencing, status, loops and shadows: next values
  // ----------------------------------------------------------------------
  always_comb
  begin
    pc_d = pc_q;
    ins_d = exec_instr_q;
    fl_d = fl_q;
    shf_d = shf_q;
    for (int k = 0; k < 4; k++)
      shw_d[k] = shw_q[k];
    lvl_d = lvl_q;
    dsp_d = dsp_status;
    rpt_on_d = rpt_on_q;
    rc_d = rc_q;
    lp_on_d = lp_on_q;
    lsv_d = lsv_q;
    lp_d = lp_q;
    lsh_d = lsh_q;
    psvb_d = psv_stall;
    psvd_d = psv_data_q;
    rd_d = w_q[rd_idx];
    swr_d = 1'b0;
    saddr_d = w_q[`CRM_SP_IDX];
    sdat_d = 16'h0000;
    vec_d = exc_vec_q;
    if (psvb_q)
      psvd_d = prog_data[15:0];
    if (flags_upd)
      fl_d = flags_in;
    if (shadow_push)
    begin
      shf_d = fl_q;
      for (int k = 0; k < 4; k++)
        shw_d[k] = w_q[k];
    end
    if (shadow_pop)
      fl_d = shf_q;
    // prefetch: next word is latched while the current one executes
    if (advance)
    begin
      ins_d = prog_data;
      pc_d = pc_q + `CRM_PC_STEP;
      if (rpt_on_q)
      begin
        pc_d = pc_q;
        rc_d = rc_q - 14'h0001;
        if (rc_q == 14'h0000)
        begin
          rpt_on_d = 1'b0;
          pc_d = pc_q + `CRM_PC_STEP;
        end
      end
      else if (lp_on_q && pc_q == lp_q.stop)
      begin
        if (lp_q.count != 14'h0000)
        begin
          lp_d.count = lp_q.count - 14'h0001;
          pc_d = lp_q.start;
        end
        else if (lsv_q)
        begin
          lp_d = lsh_q;
          lsv_d = 1'b0;
        end
        else
          lp_on_d = 1'b0;
      end
      if (rpt_begin)
      begin
        rpt_on_d = 1'b1;
        rc_d = rpt_count;
      end
      if (loop_begin)
      begin
        lsh_d = lp_q;
        lsv_d = lp_on_q;
        lp_d = loop_in;
        lp_on_d = 1'b1;
      end
      if (pc_load)
        pc_d = pc_load_val;
      // loop and repeat state survive the exception
      if (exc_ack)
      begin
        swr_d = 1'b1;
        sdat_d = {1'b0, pc_q[22:16], core_flags_word[7:0]};
        vec_d = best_vec;
        lvl_d = best_pri[3] ? `CRM_LVL_MAX : best_pri[2:0];
        pc_d = `CRM_VEC_BASE + 23'({best_vec, 1'b0});
      end
      else if (call_req)
      begin
        swr_d = 1'b1;
        sdat_d = pc_q[15:0];
      end
    end
    pc_d[0] = 1'b0;
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int k = 0; k < 16; k++)
        w_q[k] <= 16'h0000;
      w_q[`CRM_SP_IDX] <= `CRM_SP_RESET;
      for (int k = 0; k < 4; k++)
        shw_q[k] <= 16'h0000;
      pc_q <= `CRM_PC_RESET;
      exec_instr_q <= 24'h000000;
      fl_q <= '0;
      shf_q <= '0;
      lvl_q <= 3'h0;
      dsp_q <= 6'h00;
      rpt_on_q <= 1'b0;
      rc_q <= 14'h0000;
      lp_on_q <= 1'b0;
      lsv_q <= 1'b0;
      lp_q <= '0;
      lsh_q <= '0;
      psvb_q <= 1'b0;
      psv_data_q <= 16'h0000;
      rd_data_q <= 16'h0000;
      stack_wr_q <= 1'b0;
      stack_addr_q <= 16'h0000;
      stack_data_q <= 16'h0000;
      exc_vec_q <= 6'h00;
      shift_res_q <= 40'h0000000000;
    end
    else if (clk_en)
    begin
      w_q <= w_d;
      shw_q <= shw_d;
      pc_q <= pc_d;
      exec_instr_q <= ins_d;
      fl_q <= fl_d;
      shf_q <= shf_d;
      lvl_q <= lvl_d;
      dsp_q <= dsp_d;
      rpt_on_q <= rpt_on_d;
      rc_q <= rc_d;
      lp_on_q <= lp_on_d;
      lsv_q <= lsv_d;
      lp_q <= lp_d;
      lsh_q <= lsh_d;
      psvb_q <= psvb_d;
      psv_data_q <= psvd_d;
      rd_data_q <= rd_d;
      stack_wr_q <= swr_d;
      stack_addr_q <= saddr_d;
      stack_data_q <= sdat_d;
      exc_vec_q <= vec_d;
      shift_res_q <= sh_res;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence s_psv_first;
    clk_en && psv_hit && !psvb_q;
  endsequence
  sequence s_psv_second;
    psvb_q && !psv_stall;
  endsequence
  a_pc_lsb_clear: assert property (pc_q[0] == 1'b0)
    else $error("pc lsb set");
  a_sp_bit_zero: assert property (w_q[`CRM_SP_IDX][0] == 1'b0)
    else $error("stack pointer misaligned");
  a_psv_extra_cycle: assert property (s_psv_first |=> s_psv_second)
    else $error("window access not one extra cycle");
  a_exc_push_word: assert property (exc_ack |=> stack_wr_q &&
    stack_data_q == {1'b0, $past(pc_q[22:16]), $past(core_flags_word[7:0])})
    else $error("exception push word wrong");
  a_exc_sp_step: assert property (exc_ack |=>
    w_q[`CRM_SP_IDX] == $past(w_q[`CRM_SP_IDX]) + `CRM_STK_STEP)
    else $error("stack pointer not advanced on exception");
  // the level after entry is never zero and never below the level before it
  a_exc_level_up: assert property (exc_ack |=>
    lvl_q != 3'h0 && lvl_q >= $past(lvl_q))
    else $error("priority level not raised by exception");
  // sampled reset keeps the release edge out, when the word still reads zero
  a_fetch_ahead: assert property (rstn && advance |=> exec_instr_q == $past(prog_data))
    else $error("prefetch word not latched");
  a_byte_low_only: assert property (clk_en && wr_en && wr_byte && !mem_wr_en &&
    wr_idx != `CRM_SP_IDX && !(shadow_pop && wr_idx < 4'h4)
    |=> w_q[$past(wr_idx)][15:8] == $past(w_q[wr_idx][15:8]))
    else $error("byte write touched high byte");
  a_rpt_end: assert property (advance && rpt_on_q && rc_q == 14'h0000 && !rpt_begin
    |=> !rpt_on_q)
    else $error("repeat did not end");
endmodule : crm_core

// ### hdl/crm_regs.svh
/*
  Constants of the core register model: register indices, reset values,
  status word bit positions, exception counts and address steps.
  Assumes inclusion by bare name from design files.
*/
`ifndef CRM_REGS_SVH
`define CRM_REGS_SVH
// ----------------------------------------------------------------------
// register indices, reset values, address steps and vector base
// ----------------------------------------------------------------------
`define CRM_DEF_IDX 4'h0
`define CRM_SP_IDX 4'hf
`define CRM_SP_RESET 16'h0800
`define CRM_PC_RESET 23'h000000
`define CRM_PC_STEP 23'h000002
`define CRM_STK_STEP 16'h0002
`define CRM_VEC_BASE 23'h000004
// ----------------------------------------------------------------------
// status word bit positions
// ----------------------------------------------------------------------
`define CRM_FW_C 0
`define CRM_FW_Z 1
`define CRM_FW_OV 2
`define CRM_FW_N 3
`define CRM_FW_RPT 4
`define CRM_FW_LVL_LO 5
`define CRM_FW_LVL_HI 7
`define CRM_FW_DC 8
`define CRM_FW_LOOP 9
`define CRM_FW_DSP_LO 10
`define CRM_FW_DSP_HI 15
// ----------------------------------------------------------------------
// exceptions and address windows
// ----------------------------------------------------------------------
`define CRM_N_TRAP 8
`define CRM_N_IRQ 54
`define CRM_N_SRC 62
`define CRM_TRAP_LIVE 8'h0f
`define CRM_TRAP_PRI 4'h8
`define CRM_LVL_MAX 3'h7
`define CRM_PSV_BIT 15
`endif

// ### hdl/crm_pkg.sv
/*
  Types shared by the core register model.
  Assumes nothing of its surroundings.
*/
package crm_pkg;
  // arithmetic flags copied by the shadow push and pop
  typedef struct packed {
    logic dc;
    logic n;
    logic ov;
    logic z;
    logic c;
  } crm_flags_t;
  // hardware loop registers
  typedef struct packed {
    logic [22:0] start;
    logic [22:0] stop;
    logic [13:0] count;
  } crm_loop_t;
endpackage : crm_pkg

// ### hdl/crm_shifter.sv
/*
  Single-cycle barrel shifter over 40 bits.
  Assumes amt stays within -15..16; positive shifts left, negative right.
*/
`timescale 1ns/1ps
module crm_shifter
  import crm_pkg::*;
(
  input wire logic [39:0] val,
  input wire logic signed [5:0] amt,
  output logic [39:0] res
);
  // right shifts are arithmetic so a signed accumulator keeps its sign
  always_comb
  begin
    if (amt[5])
      res = 40'($signed(val) >>> 6'(-amt));
    else
      res = val << amt;
  end
endmodule : crm_shifter

// ### verification/crm_prog_mem.sv
/*
  Behavioural program memory seen by the core: answers fetch and
  visibility-window reads in the same cycle.
  Assumes the core raises psv_stall for one cycle before a window read.
*/
`timescale 1ns/1ps
module crm_prog_mem
  import crm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [22:0] fetch_addr,
  input wire logic psv_hit,
  input wire logic psv_stall,
  input wire logic [22:0] psv_addr,
  output logic [23:0] prog_data
);
  // ----------------------------------------------------------------
  // window cycle tracking
  // ----------------------------------------------------------------
  logic was_stall_q;
  // the data cycle follows the stall cycle, so remember the stall
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      was_stall_q <= 1'b0;
    else
      was_stall_q <= psv_stall;
  end
  // word pattern: upper byte differs from the low half on purpose
  always_comb
  begin
    if (was_stall_q && psv_hit)
      prog_data = {~psv_addr[7:0], psv_addr[15:0]};
    else
      prog_data = {~fetch_addr[7:0], fetch_addr[15:0]};
  end
endmodule : crm_prog_mem

// ### verification/cpu_core_register_model_tb_top.sv
/*
  Self-checking bench of the core register model with a program memory.
  Assumes one 200 MHz clock and the hand-over timing of the core.
*/
`timescale 1ns/1ps
module cpu_core_register_model_tb_top
  import crm_pkg::*;
;
  // ----------------------------------------------------------------
  // stimulus signals
  // ----------------------------------------------------------------
  logic sys_clk = 1'b0, rstn = 1'b0;
  logic wr_en = 1'b0, wr_byte = 1'b0, mem_wr_en = 1'b0, dual_src = 1'b0;
  logic [3:0] wr_idx = 4'h0, mem_wr_idx = 4'h0, rd_idx = 4'h0, tbl_idx = 4'h0;
  logic [15:0] wr_data = 16'h0000, mem_wr_data = 16'h0000, x_addr = 16'h0000;
  logic [1:0] mem_wr_be = 2'h0;
  logic special_mode = 1'b0, pc_load = 1'b0, flags_upd = 1'b0, clk_en = 1'b1;
  logic loop_begin = 1'b0;
  crm_loop_t loop_in = '0;
  logic [22:0] pc_load_val = 23'h000000;
  crm_flags_t flags_in = '0;
  logic [5:0] dsp_status = 6'h00;
  logic shadow_push = 1'b0, shadow_pop = 1'b0, rpt_begin = 1'b0;
  logic [13:0] rpt_count = 14'h0000;
  logic [7:0] vis_page = 8'h00, tbl_page = 8'h00, trap_pend = 8'h00;
  logic [53:0] irq_pend = '0;
  logic [53:0][2:0] irq_pri = '0;
  logic call_req = 1'b0, ret_req = 1'b0, shift_use_acc = 1'b0;
  logic [3:0] shift_idx = 4'h0;
  logic [39:0] acc_in = 40'h0000000000;
  logic signed [5:0] shift_amt = 6'sd0;
  logic [15:0] rd_data_q, dfr, core_flags_word, psv_data_q, stack_addr_q, stack_data_q;
  logic [15:0] sp_exp;
  logic [22:0] fetch_addr, program_counter, tbl_addr, psv_addr, p;
  logic [23:0] prog_data, exec_instr_q;
  logic [39:0] shift_res_q;
  logic [5:0] exc_vec_q;
  logic [13:0] repeat_count_reg;
  logic y_en, psv_hit, psv_stall, exc_ack, stack_wr_q, rpt_flag, lp_flag;
  int err_count = 0, comparisons = 0;

  always #2.5 sys_clk = ~sys_clk;

  crm_core u_dut (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en), .wr_en(wr_en),
    .wr_idx(wr_idx), .wr_data(wr_data), .wr_byte(wr_byte), .mem_wr_en(mem_wr_en),
    .mem_wr_idx(mem_wr_idx), .mem_wr_be(mem_wr_be), .mem_wr_data(mem_wr_data),
    .rd_idx(rd_idx), .rd_data_q(rd_data_q), .default_file_reg(dfr), .x_addr(x_addr),
    .y_addr(16'h0000), .dual_src(dual_src), .y_en(y_en), .prog_data(prog_data),
    .special_mode(special_mode), .fetch_addr(fetch_addr), .exec_instr_q(exec_instr_q),
    .pc_load(pc_load), .pc_load_val(pc_load_val), .program_counter(program_counter),
    .flags_upd(flags_upd), .flags_in(flags_in), .dsp_status(dsp_status),
    .core_flags_word(core_flags_word), .shadow_push(shadow_push), .shadow_pop(shadow_pop),
    .loop_begin(loop_begin), .loop_in(loop_in), .rpt_begin(rpt_begin), .rpt_count(rpt_count),
    .visibility_page_reg(vis_page), .table_page_reg(tbl_page), .tbl_idx(tbl_idx),
    .tbl_addr(tbl_addr), .psv_hit(psv_hit), .psv_stall(psv_stall), .psv_addr(psv_addr),
    .psv_data_q(psv_data_q), .trap_pend(trap_pend), .irq_pend(irq_pend),
    .irq_pri(irq_pri), .exc_ack(exc_ack), .exc_vec_q(exc_vec_q), .call_req(call_req),
    .ret_req(ret_req), .stack_wr_q(stack_wr_q), .stack_addr_q(stack_addr_q),
    .stack_data_q(stack_data_q), .shift_idx(shift_idx), .shift_use_acc(shift_use_acc),
    .acc_in(acc_in), .shift_amt(shift_amt), .shift_res_q(shift_res_q),
    .repeat_active_flag(rpt_flag), .loop_active_flag(lp_flag),
    .repeat_count_reg(repeat_count_reg));

  crm_prog_mem u_mem (.sys_clk(sys_clk), .rstn(rstn), .fetch_addr(fetch_addr),
    .psv_hit(psv_hit), .psv_stall(psv_stall), .psv_addr(psv_addr), .prog_data(prog_data));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // wait one edge and let its updates land
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic wr(input logic [3:0] i, input logic [15:0] d, input logic b);
    @(posedge sys_clk);
    wr_en <= 1'b1;
    wr_idx <= i;
    wr_data <= d;
    wr_byte <= b;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask : wr
  // one edge to present the index, one to register the copy
  task automatic rd(input logic [3:0] i, input logic [15:0] exp);
    @(posedge sys_clk);
    rd_idx <= i;
    tick();
    chk(rd_data_q, exp);
  endtask : rd
  task automatic final_report();
    if (err_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rd(4'hf, 16'h0800);
    wr(4'hf, 16'h0a03, 1'b0);
    rd(4'hf, 16'h0a02);
    sp_exp = 16'h0a02;
    wr(4'h2, 16'h1234, 1'b0);
    wr(4'h2, 16'hff56, 1'b1);
    rd(4'h2, 16'h1256);
    @(posedge sys_clk);
    mem_wr_en <= 1'b1;
    mem_wr_idx <= 4'h2;
    mem_wr_be <= 2'b10;
    mem_wr_data <= 16'habcd;
    @(posedge sys_clk);
    mem_wr_en <= 1'b0;
    rd(4'h2, 16'hab56);
    wr(4'h0, 16'h5a5a, 1'b0);
    tick();
    chk(dfr, 16'h5a5a);
  endtask : t_regs
  task automatic t_fetch();
    @(posedge sys_clk);
    pc_load <= 1'b1;
    pc_load_val <= 23'h400010;
    tick();
    pc_load <= 1'b0;
    chk(program_counter, 23'h400010);
    chk(fetch_addr, 23'h000010);
    @(posedge sys_clk);
    special_mode <= 1'b1;
    #1;
    chk(exec_instr_q, {8'hef, 16'h0010});
    chk(fetch_addr, 23'h400012);
    tick();
    special_mode <= 1'b0;
    chk(exec_instr_q, {8'hed, 16'h0012});
    chk(program_counter[0], 1'b0);
  endtask : t_fetch
  // window read stalls a cycle and returns the low half only
  task automatic t_psv();
    @(posedge sys_clk);
    x_addr <= 16'h8004;
    vis_page <= 8'h03;
    dual_src <= 1'b1;
    #1;
    p = program_counter;
    chk(psv_stall, 1'b1);
    chk(psv_addr, 23'h018004);
    chk(y_en, 1'b1);
    tick();
    chk(program_counter, p);
    chk(psv_stall, 1'b0);
    @(posedge sys_clk);
    x_addr <= 16'h0000;
    dual_src <= 1'b0;
    #1;
    chk(psv_data_q, 16'h8004);
    tbl_idx <= 4'h2;
    tbl_page <= 8'h05;
    #1;
    chk(tbl_addr, 23'h02ab56);
  endtask : t_psv
  task automatic t_exc();
    @(posedge sys_clk);
    pc_load <= 1'b1;
    pc_load_val <= 23'h012340;
    @(posedge sys_clk);
    pc_load <= 1'b0;
    irq_pri[5] <= 3'h3;
    irq_pend[5] <= 1'b1;
    #1;
    chk(exc_ack, 1'b1);
    @(posedge sys_clk);
    irq_pend[5] <= 1'b0;
    #1;
    chk({stack_wr_q, stack_addr_q, stack_data_q}, {1'b1, sp_exp, 16'h0100});
    chk(exc_vec_q, 6'd13);
    chk(program_counter, 23'h00001e);
    chk(core_flags_word[7:5], 3'h3);
    sp_exp = sp_exp + 16'h0002;
    rd(4'hf, sp_exp);
    @(posedge sys_clk);
    trap_pend <= 8'h02;
    #1;
    chk(exc_ack, 1'b1);
    tick();
    trap_pend <= 8'h20;
    chk(exc_vec_q, 6'd1);
    chk(core_flags_word[7:5], 3'h7);
    tick();
    chk(exc_ack, 1'b0);
    trap_pend <= 8'h00;
    sp_exp = sp_exp + 16'h0002;
    @(posedge sys_clk);
    call_req <= 1'b1;
    tick();
    call_req <= 1'b0;
    chk({stack_wr_q, stack_addr_q}, {1'b1, sp_exp});
    sp_exp = sp_exp + 16'h0002;
    rd(4'hf, sp_exp);
    @(posedge sys_clk);
    ret_req <= 1'b1;
    @(posedge sys_clk);
    ret_req <= 1'b0;
    rd(4'hf, sp_exp - 16'h0002);
  endtask : t_exc
  task automatic t_shadow();
    for (int i = 0; i < 4; i++)
      wr(i[3:0], 16'h1110 + 16'(i), 1'b0);
    @(posedge sys_clk);
    flags_upd <= 1'b1;
    flags_in <= crm_flags_t'(5'h1f);
    dsp_status <= 6'h2a;
    @(posedge sys_clk);
    flags_upd <= 1'b0;
    shadow_push <= 1'b1;
    @(posedge sys_clk);
    shadow_push <= 1'b0;
    flags_upd <= 1'b1;
    flags_in <= crm_flags_t'(5'h00);
    for (int i = 0; i < 4; i++)
      wr(i[3:0], 16'h0000, 1'b0);
    @(posedge sys_clk);
    flags_upd <= 1'b0;
    shadow_pop <= 1'b1;
    @(posedge sys_clk);
    shadow_pop <= 1'b0;
    for (int i = 0; i < 4; i++)
      rd(i[3:0], 16'h1110 + 16'(i));
    chk({core_flags_word[15:8], core_flags_word[7:5], core_flags_word[3:0]},
      {6'h2a, 2'b01, 3'h7, 4'hf});
  endtask : t_shadow
  // repeat holds the pc for count advances
  task automatic t_rpt_shift();
    @(posedge sys_clk);
    rpt_begin <= 1'b1;
    rpt_count <= 14'h0002;
    shift_use_acc <= 1'b1;
    acc_in <= 40'h0000000001;
    shift_amt <= 6'sd16;
    tick();
    rpt_begin <= 1'b0;
    p = program_counter;
    chk({rpt_flag, core_flags_word[4], repeat_count_reg}, {2'b11, 14'h0002});
    chk(shift_res_q, 40'h0000010000);
    acc_in <= 40'h4000000000;
    shift_amt <= -6'sd15;
    tick();
    chk(shift_res_q, 40'h0000800000);
    tick();
    chk(program_counter, p);
    tick();
    chk({rpt_flag, program_counter}, {1'b0, p + 23'h000002});
  endtask : t_rpt_shift
  // nested loop: the inner end restores the outer registers; then a frozen cycle
  task automatic t_loop();
    @(posedge sys_clk);
    pc_load <= 1'b1;
    pc_load_val <= 23'h000100;
    loop_begin <= 1'b1;
    loop_in <= '{start: 23'h000100, stop: 23'h000104, count: 14'h0001};
    @(posedge sys_clk);
    pc_load_val <= 23'h000200;
    loop_in <= '{start: 23'h000200, stop: 23'h000202, count: 14'h0000};
    #1;
    chk({lp_flag, core_flags_word[9]}, 2'b11);
    @(posedge sys_clk);
    pc_load <= 1'b0;
    loop_begin <= 1'b0;
    repeat (2) @(posedge sys_clk);
    pc_load <= 1'b1;
    pc_load_val <= 23'h000104;
    @(posedge sys_clk);
    pc_load <= 1'b0;
    tick();
    chk({lp_flag, program_counter}, {1'b1, 23'h000100});
    repeat (2) @(posedge sys_clk);
    tick();
    chk({lp_flag, program_counter}, {1'b0, 23'h000106});
    clk_en <= 1'b0;
    tick();
    chk(program_counter, 23'h000106);
    clk_en <= 1'b1;
  endtask : t_loop

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    t_regs();
    t_fetch();
    t_psv();
    t_exc();
    t_shadow();
    t_rpt_shift();
    t_loop();
    final_report();
  end
  // the scenarios need well under a thousand cycles
  initial
  begin
    #20000;
    err_count++;
    final_report();
  end
endmodule : cpu_core_register_model_tb_top
